// *** common/nvh_cfg.svh ***
`ifndef NVH_CFG_SVH
`define NVH_CFG_SVH
// ----------------------------------------
// Sequence addresses
// ----------------------------------------
`define NVH_SEQ_A1 11'h000
`define NVH_SEQ_A2 11'h555
`define NVH_SEQ_A3 11'h2AA
`define NVH_SEQ_A4 11'h7FF
`define NVH_SEQ_A5 11'h0F0
`define NVH_SEQ_STORE 11'h70F
`define NVH_SEQ_RECALL 11'h70E
`define NVH_SEQ_TEST 11'h39C
// ----------------------------------------
// Timing
// ----------------------------------------
`define NVH_CLK_MHZ 125
`define NVH_CYCLE_NS 48
`define NVH_CYCLE_CLKS ((`NVH_CYCLE_NS * `NVH_CLK_MHZ + 999) / 1000)
`define NVH_STORE_MS 10
`define NVH_STORE_CLKS (`NVH_STORE_MS * 1000 * `NVH_CLK_MHZ)
`define NVH_RECALL_US 20
`define NVH_RECALL_CLKS (`NVH_RECALL_US * `NVH_CLK_MHZ)
`define NVH_RESTORE_US 650
`define NVH_RESTORE_CLKS (`NVH_RESTORE_US * `NVH_CLK_MHZ)
`endif

// *** common/nvh_pkg.sv ***
`default_nettype none
package nvh_pkg;
	typedef enum logic [1:0] {NVH_OP_READ, NVH_OP_WRITE, NVH_OP_STORE, NVH_OP_RECALL} nvh_op_t;
	typedef enum {NVH_IDLE, NVH_SETUP, NVH_STROBE, NVH_HOLD, NVH_WAIT} nvh_state_t;
endpackage
`default_nettype wire

// *** src/nvh_host.sv ***
// Function
// - Host holds address stable through the whole write.
// - Host keeps output enable high in writes; device drops drivers otherwise.
// - Host holds write enable high to the end of power-up recall only when idle sees power_fail high; after reset it is ready at once.
// - Store follows six reads 000,555,2AA,7FF,0F0,70F in order.
// - Recall uses same five reads then 70E.
// - Only reads count in the sequence; output enable is free.
// - Each step is a select-clocked read with write enable high.
// - Host's store and recall sequences never issue the reserved test sequence ending 39C; plain reads pass any address.
`timescale 1ns/1ps
`default_nettype none
`include "nvh_cfg.svh"
module nvh_host #(
	parameter int STORE_CLKS = `NVH_STORE_CLKS,
	parameter int RESTORE_CLKS = `NVH_RESTORE_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire nvh_pkg::nvh_op_t req_op,
	input wire logic [10:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic power_fail,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic [10:0] byte_select_lines,
	output logic [7:0] byte_io_lines_o,
	output logic byte_io_lines_oe_n,
	input wire logic [7:0] byte_io_lines_i,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic write_en_n
);
	localparam logic [7:0] CYC = 8'(`NVH_CYCLE_CLKS);
	typedef struct packed {
		nvh_pkg::nvh_state_t st;
		nvh_pkg::nvh_op_t op;
		logic [2:0] step;
		logic [31:0] cnt;
		logic [2:0] pf_sync;
		logic pf;
		logic ready;
		logic rvalid;
		logic [7:0] rdata;
		logic [10:0] addr;
		logic [7:0] wdata;
		logic oe_n;
		logic cs_n;
		logic g_n;
		logic we_n;
		logic [2:0][7:0] io_sync;
		logic [7:0] io;
	} nvh_st_t;
	nvh_st_t s, n;
	logic [10:0] seq_addr;
	// ----------------------------------------
	// Address of the next sequence step
	// ----------------------------------------
	always_comb begin
		case (s.step)
			3'h0: seq_addr = `NVH_SEQ_A2;
			3'h1: seq_addr = `NVH_SEQ_A3;
			3'h2: seq_addr = `NVH_SEQ_A4;
			3'h3: seq_addr = `NVH_SEQ_A5;
			default: seq_addr = (s.op == nvh_pkg::NVH_OP_STORE) ? `NVH_SEQ_STORE : `NVH_SEQ_RECALL;
		endcase
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		n = s;
		n.rvalid = 1'b0;
		n.pf_sync = {s.pf_sync[1:0], power_fail};
		if (s.pf_sync[2] == s.pf_sync[1]) begin
			n.pf = s.pf_sync[2];
		end
		// Data pins pass three stages too; the strobe outlasts them, so read data is settled
		n.io_sync = {s.io_sync[1:0], byte_io_lines_i};
		if (s.io_sync[2] == s.io_sync[1]) begin
			n.io = s.io_sync[2];
		end
		case (s.st)
			nvh_pkg::NVH_IDLE: begin
				n.cs_n = 1'b1;
				n.g_n = 1'b1;
				n.we_n = 1'b1;
				n.oe_n = 1'b1;
				if (s.pf) begin
					// Supply low: wait out the device's store and restore before new access
					n.ready = 1'b0;
					n.cnt = 32'(RESTORE_CLKS);
				end else if (s.cnt != 32'h0) begin
					n.cnt = s.cnt - 32'h1;
					n.ready = (s.cnt == 32'h1);
				end else if (s.ready && req_valid) begin
					n.ready = 1'b0;
					n.op = req_op;
					n.step = 3'h0;
					n.wdata = req_wdata;
					if (req_op == nvh_pkg::NVH_OP_STORE || req_op == nvh_pkg::NVH_OP_RECALL) begin
						n.addr = `NVH_SEQ_A1;
					end else begin
						n.addr = req_addr;
					end
					n.st = nvh_pkg::NVH_SETUP;
				end else begin
					n.ready = 1'b1;
				end
			end
			nvh_pkg::NVH_SETUP: begin
				// Address settles before the strobe falls
				n.cnt = {24'h0, CYC};
				n.cs_n = 1'b0;
				if (s.op == nvh_pkg::NVH_OP_WRITE) begin
					n.we_n = 1'b0;
					n.g_n = 1'b1;
					n.oe_n = 1'b0;
				end else begin
					n.we_n = 1'b1;
					n.g_n = 1'b0;
				end
				n.st = nvh_pkg::NVH_STROBE;
			end
			nvh_pkg::NVH_STROBE: begin
				if (s.cnt != 32'h0) begin
					n.cnt = s.cnt - 32'h1;
				end else begin
					if (s.op != nvh_pkg::NVH_OP_WRITE) begin
						n.rdata = s.io;
					end
					n.cs_n = 1'b1;
					n.we_n = 1'b1;
					n.g_n = 1'b1;
					n.st = nvh_pkg::NVH_HOLD;
				end
			end
			nvh_pkg::NVH_HOLD: begin
				// Address and data held one cycle past the rising strobe
				n.oe_n = 1'b1;
				if (s.op == nvh_pkg::NVH_OP_READ || s.op == nvh_pkg::NVH_OP_WRITE) begin
					n.rvalid = 1'b1;
					n.st = nvh_pkg::NVH_IDLE;
				end else if (s.step == 3'h5) begin
					n.rvalid = 1'b1;
					n.st = nvh_pkg::NVH_WAIT;
					n.cnt = (s.op == nvh_pkg::NVH_OP_STORE) ? 32'(STORE_CLKS) : 32'(`NVH_RECALL_CLKS);
				end else begin
					n.step = s.step + 3'h1;
					n.st = nvh_pkg::NVH_SETUP;
				end
			end
			nvh_pkg::NVH_WAIT: begin
				// No pin activity: the device ignores inputs until done
				if (s.cnt != 32'h0) begin
					n.cnt = s.cnt - 32'h1;
				end else begin
					n.ready = 1'b1;
					n.st = nvh_pkg::NVH_IDLE;
				end
			end
			default: n.st = nvh_pkg::NVH_IDLE;
		endcase
		if (s.st == nvh_pkg::NVH_HOLD && s.step != 3'h5 && s.op[1]) begin
			n.addr = seq_addr;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{st: nvh_pkg::NVH_IDLE, op: nvh_pkg::NVH_OP_READ, step: 3'h0, cnt: 32'h0, pf_sync: 3'h0,
				pf: 1'b0, ready: 1'b0, rvalid: 1'b0, rdata: 8'h00, addr: 11'h000, wdata: 8'h00,
				oe_n: 1'b1, cs_n: 1'b1, g_n: 1'b1, we_n: 1'b1, io_sync: 24'h000000, io: 8'h00};
		end else begin
			s <= n;
		end
	end
	assign req_ready = s.ready;
	assign rsp_valid = s.rvalid;
	assign rsp_rdata = s.rdata;
	assign byte_select_lines = s.addr;
	assign byte_io_lines_o = s.wdata;
	assign byte_io_lines_oe_n = s.oe_n;
	assign chip_sel_n = s.cs_n;
	assign out_en_n = s.g_n;
	assign write_en_n = s.we_n;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_NO_DRIVE_ON_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!s.g_n |-> s.oe_n) else $error("Host drives bus while reading");
	AST_WRITE_DRIVES: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!s.we_n && !s.cs_n) |-> (!s.oe_n && s.g_n)) else $error("Write without data drive");
	AST_WE_HIGH_IN_SEQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s.op[1] && !s.cs_n) |-> s.we_n) else $error("Write strobe during sequence");
	AST_ADDR_STABLE_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!s.we_n && !s.cs_n) |=> $stable(s.addr)) else $error("Address moved during write");
	AST_WE_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s.st == nvh_pkg::NVH_IDLE |-> s.we_n) else $error("Write enable low when idle");
	AST_NO_TEST_SEQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s.op[1] && !s.cs_n) |-> s.addr != `NVH_SEQ_TEST) else $error("Reserved address issued");
	AST_FIRST_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s.op[1] && s.step == 3'h0 && !s.cs_n) |-> s.addr == `NVH_SEQ_A1) else $error("Bad first step");
	AST_SIXTH_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s.op == nvh_pkg::NVH_OP_RECALL && s.step == 3'h5 && !s.cs_n) |-> s.addr == `NVH_SEQ_RECALL)
		else $error("Bad recall code");
	AST_SIXTH_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(s.op == nvh_pkg::NVH_OP_STORE && s.step == 3'h5 && !s.cs_n) |-> s.addr == `NVH_SEQ_STORE)
		else $error("Bad store code");
	AST_WAIT_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s.st == nvh_pkg::NVH_WAIT |-> (s.cs_n && !s.ready)) else $error("Access during transfer");
endmodule // nvh_host
`default_nettype wire

// *** sim/nvh_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nvh_cfg.svh"
// ----
// Device model
// ----
module nvh_dev (
	input wire logic [10:0] addr,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_n,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic pf,
	output logic [7:0] dq
);
	logic [7:0] mem [2048];
	logic [7:0] nv [2048];
	logic [7:0] last = 8'h00;
	logic [2:0] step = 3'h0;
	logic w = 1'b0;
	logic dirty = 1'b0;
	wire [54:0] seq = {`NVH_SEQ_A5, `NVH_SEQ_A4, `NVH_SEQ_A3, `NVH_SEQ_A2, `NVH_SEQ_A1};
	wire rd = !cs_n && !oe_n && we_n;
	wire wr = !cs_n && !we_n;
	// Released bus shows the inverse so a stale byte never passes
	assign dq = !dq_oe_n ? dq_o : rd ? mem[addr] : ~last;
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 8'h00;
			nv[i] = 8'h00;
		end
	end
	always @(dq) if (!dq_oe_n || rd) last = dq;
	always @(posedge wr) w = 1'b1;
	always @(negedge wr) begin
		mem[addr] = dq;
		dirty = 1'b1;
	end
	always @(posedge cs_n) begin
		if (w) step = 3'h0;
		else if (step == 3'h5 && addr == `NVH_SEQ_STORE) begin
			if (!pf) nv = mem;
			if (!pf) dirty = 1'b0;
			step = 3'h0;
		end else if (step == 3'h5 && addr == `NVH_SEQ_RECALL) begin
			mem = nv;
			dirty = 1'b0;
			step = 3'h0;
		end else if (addr == `NVH_SEQ_A1) step = 3'h1;
		else if (step < 3'h5 && addr == seq[int'(step) * 11 +: 11]) step = step + 3'h1;
		else step = 3'h0;
		w = 1'b0;
	end
	always @(posedge pf) if (dirty) begin
		nv = mem;
		dirty = 1'b0;
	end
	always @(negedge pf) mem = nv;
endmodule // nvh_dev
`default_nettype wire

// *** sim/nvh_host_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module nvh_host_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, power_fail = 1'b0;
	nvh_pkg::nvh_op_t req_op = nvh_pkg::NVH_OP_READ;
	logic [10:0] req_addr = 11'h000, addr;
	logic [7:0] req_wdata = 8'h00, rd, rsp_rdata, io_o, io_i;
	logic req_ready, rsp_valid, io_oe_n, cs_n, oe_n, we_n;
	int fail_count = 0, n_checks = 0, cyc = 0;
	// Short timers keep the run brief
	nvh_host #(.STORE_CLKS(50), .RESTORE_CLKS(40)) nvh_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.power_fail(power_fail), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.byte_select_lines(addr), .byte_io_lines_o(io_o), .byte_io_lines_oe_n(io_oe_n),
		.byte_io_lines_i(io_i), .chip_sel_n(cs_n), .out_en_n(oe_n), .write_en_n(we_n));
	nvh_dev nvh_dev_inst (.addr(addr), .dq_o(io_o), .dq_oe_n(io_oe_n), .cs_n(cs_n), .oe_n(oe_n),
		.we_n(we_n), .pf(power_fail), .dq(io_i));
	initial forever #4 clk_sys = ~clk_sys;
	task stop_test;
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	always @(negedge clk_sys) begin
		if (we_n === 1'b0) chk8({6'h00, oe_n, io_oe_n}, 8'h02);
		if (power_fail) chk1(we_n, 1'b1);
	end
	task req(input nvh_pkg::nvh_op_t op, input logic [10:0] a, input logic [7:0] d);
		int i;
		i = 0;
		@(negedge clk_sys);
		// A recall keeps ready low for thousands of cycles
		while (req_ready !== 1'b1 && i < 3000) begin
			@(negedge clk_sys);
			i++;
		end
		chk1(req_ready, 1'b1);
		req_op = op;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		i = 0;
		while (rsp_valid !== 1'b1 && i < 500) begin
			@(negedge clk_sys);
			i++;
		end
		chk1(rsp_valid, 1'b1);
		rd = rsp_rdata;
	endtask
	// Both ends of the array, back to back
	task t_rw;
		req(nvh_pkg::NVH_OP_WRITE, 11'h000, 8'hA5);
		req(nvh_pkg::NVH_OP_WRITE, 11'h7FF, 8'h5A);
		req(nvh_pkg::NVH_OP_READ, 11'h000, 8'h00);
		chk8(rd, 8'hA5);
		req(nvh_pkg::NVH_OP_READ, 11'h7FF, 8'h00);
		chk8(rd, 8'h5A);
	endtask
	// Saved copy must come back after an overwrite
	task t_sr;
		req(nvh_pkg::NVH_OP_WRITE, 11'h123, 8'h3C);
		req(nvh_pkg::NVH_OP_STORE, 11'h000, 8'h00);
		req(nvh_pkg::NVH_OP_WRITE, 11'h123, 8'hC3);
		req(nvh_pkg::NVH_OP_READ, 11'h123, 8'h00);
		chk8(rd, 8'hC3);
		req(nvh_pkg::NVH_OP_RECALL, 11'h000, 8'h00);
		req(nvh_pkg::NVH_OP_READ, 11'h123, 8'h00);
		chk8(rd, 8'h3C);
	endtask
	// Supply loss with dirty data, then restore
	task t_pf;
		req(nvh_pkg::NVH_OP_WRITE, 11'h123, 8'h77);
		@(negedge clk_sys);
		power_fail = 1'b1;
		repeat (10) @(negedge clk_sys);
		chk1(req_ready, 1'b0);
		power_fail = 1'b0;
		repeat (20) @(negedge clk_sys);
		chk1(req_ready, 1'b0);
		req(nvh_pkg::NVH_OP_READ, 11'h123, 8'h00);
		chk8(rd, 8'h77);
	endtask
	// Reset in mid-run, then the array still answers
	task t_rst;
		@(negedge clk_sys);
		rst_n = 1'b0;
		@(negedge clk_sys);
		chk1(req_ready, 1'b0);
		chk1(we_n, 1'b1);
		rst_n = 1'b1;
		req(nvh_pkg::NVH_OP_READ, 11'h7FF, 8'h00);
		chk8(rd, 8'h5A);
	endtask
	initial begin
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		t_rw();
		t_sr();
		t_pf();
		t_rst();
		stop_test();
	end
endmodule // nvh_host_tb_top
`default_nettype wire
